//--- core/slot_xconnect_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// - A network slot takes the frame-relay tag only if free or already tagged.
// - With discovery on, free slots showing frame-relay traffic get the tag.
// - With discovery off, tags change only by explicit configuration writes.
// - DSX-1 mappings are refused while the DSX-1 interface is disabled.
// - A DSX-1 mapping lands only on a free slot or one already DSX-1 mapped.
// - Each DSX-1 slot maps to at most one network slot.
// - Stepping offers free DSX-1 slots in ascending order, then returns the slot to free.
// - Each DS0 holds a setting for signaling carriage and alarm code.
// - Loss of signal, out of frame or AIS declares the interface alarm.
// - On a new alarm the outgoing signaling is forced idle for two seconds.
// - User-defined patterns are sent at once, with no idle period.
// - After the idle period the configured hold code is sent during alarm.
// - When the alarm clears, received signaling passes through unchanged.
// - Plain robbed-bit slots pass signaling, and all ones during alarm.
// - Only cross-connected DS0s are conditioned; others see nothing.
// - Toward a D4-framed interface the C and D bits are cleared only in conditioned codes sent during alarm.
module slot_xconnect_core #(
   parameter int NUM_SLOTS = xconn_pkg::NUM_SLOTS,
   parameter int TICK_CYCLES = xconn_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic SYS_RST_IN,
   // Register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [15:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [15:0] REG_RDATA_OUT,
   output logic IRQ_OUT,
   // Framer alarms
   input wire logic NET_LOS_IN,
   input wire logic NET_OOF_IN,
   input wire logic NET_AIS_IN,
   input wire logic DSX_LOS_IN,
   input wire logic DSX_OOF_IN,
   input wire logic DSX_AIS_IN,
   input wire logic [23:0] NET_FR_DETECT_IN,
   // Received signaling
   input wire logic NET_RX_VALID_IN,
   input wire logic [4:0] NET_RX_SLOT_IN,
   input wire logic [3:0] NET_RX_SIG_IN,
   input wire logic DSX_RX_VALID_IN,
   input wire logic [4:0] DSX_RX_SLOT_IN,
   input wire logic [3:0] DSX_RX_SIG_IN,
   // Transmitted signaling
   output logic DSX_TX_VALID_OUT,
   output logic [4:0] DSX_TX_SLOT_OUT,
   output logic [3:0] DSX_TX_SIG_OUT,
   output logic NET_TX_VALID_OUT,
   output logic [4:0] NET_TX_SLOT_OUT,
   output logic [3:0] NET_TX_SIG_OUT
);
   xconn_pkg::slot_kind_e kind_q [NUM_SLOTS];
   xconn_pkg::slot_kind_e kind_d [NUM_SLOTS];
   logic [4:0] map_q [NUM_SLOTS];
   logic [4:0] map_d [NUM_SLOTS];
   logic [10:0] cond_q [NUM_SLOTS];
   logic [10:0] cond_d [NUM_SLOTS];
   logic [3:0] ctrl_q, ctrl_d;
   logic [2:0] int_stat_q, int_stat_d, int_en_q, int_en_d, ev;
   logic [15:0] rdata_q, rdata_d;
   logic [1:0] cga_q, cga_d, idle_act;
   logic [11:0] idle_q [2];
   logic [11:0] idle_d [2];
   logic [15:0] tick_q, tick_d;
   logic tick, reject, dup, free_any, auto_on, dsx_en;
   logic [NUM_SLOTS-1:0] used, fr_mask, disc_mask;
   logic [4:0] first_free, wr_idx, cand;
   logic slot_hit, cond_hit, step_hit, cand_ok, wr_ok;
   xconn_pkg::slot_kind_e wr_kind, cur_kind;
   logic dtx_v_d, ntx_v_d, net_map_ok, dsx_map_ok;
   logic [4:0] dtx_s_d, ntx_s_d, nrx_idx, drx_idx, net_src;
   logic [3:0] dtx_g_d, ntx_g_d;
   logic [10:0] net_cfg;

   assign auto_on = ctrl_q[xconn_pkg::CTRL_AUTO_BIT];
   assign dsx_en = ctrl_q[xconn_pkg::CTRL_DSXEN_BIT];
   assign wr_idx = REG_ADDR_IN[4:0];
   assign slot_hit = REG_WR_IN && (REG_ADDR_IN[7:5] == 3'h1)
      && (int'(wr_idx) < NUM_SLOTS);
   assign cond_hit = (REG_ADDR_IN[7:5] == 3'h2) && (int'(wr_idx) < NUM_SLOTS);
   assign step_hit = REG_WR_IN && (REG_ADDR_IN[7:5] == 3'h3)
      && (int'(wr_idx) < NUM_SLOTS);
   assign wr_kind = xconn_pkg::slot_kind_e'(REG_WDATA_IN[6:5]);
   assign cur_kind = kind_q[(int'(wr_idx) < NUM_SLOTS) ? wr_idx : 5'h00];

   // Ownership summary of the slot table
   always_comb
   begin
      used = '0;
      dup = 1'b0;
      fr_mask = '0;
      disc_mask = '0;
      for (int n = 0; n < NUM_SLOTS; n++)
      begin
         fr_mask[n] = (kind_q[n] == xconn_pkg::SLOT_FR);
         disc_mask[n] = auto_on && NET_FR_DETECT_IN[n]
            && (kind_q[n] == xconn_pkg::SLOT_FREE);
         if (kind_q[n] == xconn_pkg::SLOT_DSX && int'(map_q[n]) < NUM_SLOTS)
         begin
            if (used[map_q[n]])
               dup = 1'b1;
            used[map_q[n]] = 1'b1;
         end
      end
      first_free = 5'h00;
      free_any = 1'b0;
      cand = 5'h00;
      cand_ok = 1'b0;
      for (int d = NUM_SLOTS - 1; d >= 0; d--)
      begin
         if (!used[d])
         begin
            first_free = 5'(d);
            free_any = 1'b1;
            if (cur_kind != xconn_pkg::SLOT_DSX || d > int'(map_q[wr_idx]))
            begin
               cand = 5'(d);
               cand_ok = 1'b1;
            end
         end
      end
   end

   // Configuration writes and slot discovery
   always_comb
   begin
      kind_d = kind_q;
      map_d = map_q;
      cond_d = cond_q;
      ctrl_d = ctrl_q;
      reject = 1'b0;
      wr_ok = 1'b0;
      if (REG_WR_IN && REG_ADDR_IN == xconn_pkg::ADDR_CTRL)
         ctrl_d = REG_WDATA_IN[3:0];
      else if (slot_hit)
      begin
         case (wr_kind)
            xconn_pkg::SLOT_FREE:
               wr_ok = !(auto_on && cur_kind == xconn_pkg::SLOT_FR);
            xconn_pkg::SLOT_FR:
               wr_ok = !auto_on && (cur_kind == xconn_pkg::SLOT_FREE
                  || cur_kind == xconn_pkg::SLOT_FR);
            xconn_pkg::SLOT_DSX:
               wr_ok = dsx_en
                  && (cur_kind == xconn_pkg::SLOT_FREE
                  || cur_kind == xconn_pkg::SLOT_DSX)
                  && int'(REG_WDATA_IN[4:0]) < NUM_SLOTS
                  && (!used[REG_WDATA_IN[4:0]]
                  || (cur_kind == xconn_pkg::SLOT_DSX
                  && map_q[wr_idx] == REG_WDATA_IN[4:0]));
            default:
               wr_ok = cur_kind == xconn_pkg::SLOT_FREE
                  || cur_kind == xconn_pkg::SLOT_OTHER;
         endcase
         if (wr_ok)
         begin
            kind_d[wr_idx] = wr_kind;
            map_d[wr_idx] = REG_WDATA_IN[4:0];
         end
         else
            reject = 1'b1;
      end
      else if (REG_WR_IN && cond_hit)
         cond_d[wr_idx] = REG_WDATA_IN[10:0];
      else if (step_hit)
      begin
         if (dsx_en && (cur_kind == xconn_pkg::SLOT_FREE
            || cur_kind == xconn_pkg::SLOT_DSX))
         begin
            kind_d[wr_idx] = cand_ok ? xconn_pkg::SLOT_DSX
               : xconn_pkg::SLOT_FREE;
            map_d[wr_idx] = cand;
         end
         else
            reject = 1'b1;
      end
      for (int n = 0; n < NUM_SLOTS; n++)
         if (disc_mask[n] && kind_d[n] == xconn_pkg::SLOT_FREE)
            kind_d[n] = xconn_pkg::SLOT_FR;
   end

   // Alarms, idle timers and interrupt status
   always_comb
   begin
      cga_d[0] = NET_LOS_IN || NET_OOF_IN || NET_AIS_IN;
      cga_d[1] = DSX_LOS_IN || DSX_OOF_IN || DSX_AIS_IN;
      tick = (tick_q == 16'(TICK_CYCLES - 1));
      tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
      for (int i = 0; i < 2; i++)
      begin
         idle_act[i] = (idle_q[i] != 12'h000);
         if (!cga_d[i])
            idle_d[i] = 12'h000;
         else if (!cga_q[i])
            idle_d[i] = xconn_pkg::IDLE_LOAD;
         else if (tick && idle_act[i])
            idle_d[i] = idle_q[i] - 12'h001;
         else
            idle_d[i] = idle_q[i];
      end
      ev = {reject, cga_d & ~cga_q};
      int_stat_d = int_stat_q;
      int_en_d = int_en_q;
      if (REG_WR_IN && REG_ADDR_IN == xconn_pkg::ADDR_INT_CLR)
         int_stat_d = int_stat_q & ~REG_WDATA_IN[2:0];
      if (REG_WR_IN && REG_ADDR_IN == xconn_pkg::ADDR_INT_EN)
         int_en_d = REG_WDATA_IN[2:0];
      int_stat_d = int_stat_d | ev;
      rdata_d = 16'h0000;
      if (!REG_RD_IN)
         rdata_d = 16'h0000;
      else if (REG_ADDR_IN == xconn_pkg::ADDR_CTRL)
         rdata_d = {12'h000, ctrl_q};
      else if (REG_ADDR_IN == xconn_pkg::ADDR_STATUS)
         rdata_d = {12'h000, idle_act, cga_q};
      else if (REG_ADDR_IN == xconn_pkg::ADDR_INT_STAT)
         rdata_d = {13'h0000, int_stat_q};
      else if (REG_ADDR_IN == xconn_pkg::ADDR_INT_EN)
         rdata_d = {13'h0000, int_en_q};
      else if (REG_ADDR_IN[7:5] == 3'h1 && int'(wr_idx) < NUM_SLOTS)
         rdata_d = {9'h000, kind_q[wr_idx], map_q[wr_idx]};
      else if (cond_hit)
         rdata_d = {5'h00, cond_q[wr_idx]};
   end

   // Outgoing signaling code for one cross-connected DS0
   function automatic logic [3:0] cond_sig(input logic alarm,
      input logic idle, input logic d4, input logic [10:0] cfg,
      input logic [3:0] sig);
      logic [3:0] res;
      logic [3:0] held;
      res = sig;
      held = cfg[xconn_pkg::COND_HOLD_LSB +: 4];
      if (alarm && cfg[1:0] == xconn_pkg::MODE_RBS)
         res = xconn_pkg::ALL_ONES_SIG;
      else if (alarm && cfg[1:0] == xconn_pkg::MODE_COND)
      begin
         if (cfg[xconn_pkg::COND_USER_BIT])
            res = held;
         else if (idle)
            res = cfg[xconn_pkg::COND_IDLE_LSB +: 4];
         else
            res = held;
         if (d4)
            res = res & xconn_pkg::D4_MASK;
      end
      return res;
   endfunction

   // Signaling cross-connect in both directions
   always_comb
   begin
      nrx_idx = (int'(NET_RX_SLOT_IN) < NUM_SLOTS) ? NET_RX_SLOT_IN : 5'h00;
      net_map_ok = (int'(NET_RX_SLOT_IN) < NUM_SLOTS)
         && kind_q[nrx_idx] == xconn_pkg::SLOT_DSX;
      net_cfg = cond_q[map_q[nrx_idx]];
      dtx_v_d = NET_RX_VALID_IN && net_map_ok;
      dtx_s_d = map_q[nrx_idx];
      dtx_g_d = cond_sig(cga_q[0], idle_act[0],
         ctrl_q[xconn_pkg::CTRL_DSXD4_BIT], net_cfg, NET_RX_SIG_IN);
      drx_idx = (int'(DSX_RX_SLOT_IN) < NUM_SLOTS) ? DSX_RX_SLOT_IN : 5'h00;
      net_src = 5'h00;
      dsx_map_ok = 1'b0;
      for (int n = 0; n < NUM_SLOTS; n++)
         if (kind_q[n] == xconn_pkg::SLOT_DSX && map_q[n] == DSX_RX_SLOT_IN)
         begin
            net_src = 5'(n);
            dsx_map_ok = 1'b1;
         end
      ntx_v_d = DSX_RX_VALID_IN && dsx_map_ok;
      ntx_s_d = net_src;
      ntx_g_d = cond_sig(cga_q[1], idle_act[1],
         ctrl_q[xconn_pkg::CTRL_NETD4_BIT], cond_q[drx_idx], DSX_RX_SIG_IN);
   end

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         for (int n = 0; n < NUM_SLOTS; n++)
         begin
            kind_q[n] <= xconn_pkg::SLOT_FREE;
            map_q[n] <= 5'h00;
            cond_q[n] <= xconn_pkg::COND_RESET;
         end
         ctrl_q <= xconn_pkg::CTRL_RESET;
         int_stat_q <= 3'h0;
         int_en_q <= 3'h0;
         rdata_q <= 16'h0000;
         cga_q <= 2'h0;
         idle_q[0] <= 12'h000;
         idle_q[1] <= 12'h000;
         tick_q <= 16'h0000;
         DSX_TX_VALID_OUT <= 1'b0;
         DSX_TX_SLOT_OUT <= 5'h00;
         DSX_TX_SIG_OUT <= 4'h0;
         NET_TX_VALID_OUT <= 1'b0;
         NET_TX_SLOT_OUT <= 5'h00;
         NET_TX_SIG_OUT <= 4'h0;
      end
      else
      begin
         kind_q <= kind_d;
         map_q <= map_d;
         cond_q <= cond_d;
         ctrl_q <= ctrl_d;
         int_stat_q <= int_stat_d;
         int_en_q <= int_en_d;
         rdata_q <= rdata_d;
         cga_q <= cga_d;
         idle_q <= idle_d;
         tick_q <= tick_d;
         DSX_TX_VALID_OUT <= dtx_v_d;
         DSX_TX_SLOT_OUT <= dtx_s_d;
         DSX_TX_SIG_OUT <= dtx_g_d;
         NET_TX_VALID_OUT <= ntx_v_d;
         NET_TX_SLOT_OUT <= ntx_s_d;
         NET_TX_SIG_OUT <= ntx_g_d;
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign IRQ_OUT = |(int_stat_q & int_en_q);

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   fr_accept_a: assert property (
      slot_hit && wr_kind == xconn_pkg::SLOT_FR
      && cur_kind == xconn_pkg::SLOT_DSX
      |=> kind_q[$past(wr_idx)] == xconn_pkg::SLOT_DSX)
      else $error("frame-relay tag overwrote a DSX-1 slot");
   auto_tag_a: assert property (
      disc_mask != '0 && !REG_WR_IN
      |=> (fr_mask & $past(disc_mask)) == $past(disc_mask))
      else $error("discovered slot not tagged");
   manual_hold_a: assert property (
      !auto_on && !REG_WR_IN |=> fr_mask == $past(fr_mask))
      else $error("frame-relay tags changed without a write");
   dsx_off_a: assert property (
      slot_hit && wr_kind == xconn_pkg::SLOT_DSX && !dsx_en
      |=> kind_q[$past(wr_idx)] == $past(cur_kind) && int_stat_q[2])
      else $error("DSX-1 mapping taken while disabled");
   dsx_target_a: assert property (
      slot_hit && wr_kind == xconn_pkg::SLOT_DSX
      && cur_kind == xconn_pkg::SLOT_FR
      |=> kind_q[$past(wr_idx)] == xconn_pkg::SLOT_FR)
      else $error("DSX-1 mapping replaced a frame-relay slot");
   dsx_unique_a: assert property (!dup)
      else $error("DSX-1 slot mapped twice");
   step_first_a: assert property (
      step_hit && dsx_en && cur_kind == xconn_pkg::SLOT_FREE && free_any
      |=> kind_q[$past(wr_idx)] == xconn_pkg::SLOT_DSX
      && map_q[$past(wr_idx)] == $past(first_free))
      else $error("step did not offer the lowest free slot");
   cfg_store_a: assert property (
      REG_WR_IN && cond_hit ##1 !REG_WR_IN ##1 REG_RD_IN
      && REG_ADDR_IN == $past(REG_ADDR_IN, 2)
      |=> REG_RDATA_OUT[10:0] == $past(REG_WDATA_IN[10:0], 3))
      else $error("conditioning setting not stored");
   cga_decl_a: assert property (
      NET_LOS_IN || NET_OOF_IN || NET_AIS_IN |=> cga_q[0])
      else $error("alarm not declared");
   idle_start_a: assert property (
      $rose(cga_q[0]) |-> idle_q[0] == xconn_pkg::IDLE_LOAD
      ##1 (idle_act[0] || !cga_q[0]) [*7])
      else $error("idle period did not start");
   user_now_a: assert property (
      ntx_v_d && cga_q[1] && cond_q[drx_idx][1:0] == xconn_pkg::MODE_COND
      && cond_q[drx_idx][2] && !ctrl_q[2]
      |=> NET_TX_SIG_OUT == $past(cond_q[drx_idx][10:7]))
      else $error("user pattern not sent at once");
   hold_code_a: assert property (
      dtx_v_d && cga_q[0] && !idle_act[0] && !ctrl_q[3]
      && net_cfg[1:0] == xconn_pkg::MODE_COND
      |=> DSX_TX_SIG_OUT == $past(net_cfg[10:7]))
      else $error("hold code not sent");
   pass_clear_a: assert property (
      dtx_v_d && !cga_q[0] |=> DSX_TX_SIG_OUT == $past(NET_RX_SIG_IN))
      else $error("signaling not passed through");
   rbs_ones_a: assert property (
      dtx_v_d && cga_q[0] && net_cfg[1:0] == xconn_pkg::MODE_RBS
      |=> DSX_TX_SIG_OUT == xconn_pkg::ALL_ONES_SIG)
      else $error("robbed-bit slot not all ones in alarm");
   unmapped_a: assert property (
      NET_RX_VALID_IN && !net_map_ok |=> !DSX_TX_VALID_OUT)
      else $error("unmapped DS0 forwarded");
   d4_mask_a: assert property (
      dtx_v_d && cga_q[0] && ctrl_q[3]
      && net_cfg[1:0] == xconn_pkg::MODE_COND |=> DSX_TX_SIG_OUT[1:0] == 2'h0)
      else $error("C and D bits sent toward D4");
   idle_cover_c: cover property ($rose(cga_q[0]) ##[1:20] !idle_act[0]);
   step_cover_c: cover property (step_hit && cand_ok);
   reject_cover_c: cover property (reject);
   irq_cover_c: cover property ($rose(IRQ_OUT));
endmodule // slot_xconnect_core

//--- common/xconn_pkg.sv
package xconn_pkg;
   // Sizes
   localparam int NUM_SLOTS = 24;
   localparam int SLOT_W = 5;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int COND_W = 11;
   localparam int NUM_EV = 3;

   // Slot ownership
   typedef enum logic [1:0] {
      SLOT_FREE = 2'h0,
      SLOT_FR = 2'h1,
      SLOT_DSX = 2'h2,
      SLOT_OTHER = 2'h3
   } slot_kind_e;

   // Signaling modes per DS0
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_RBS = 2'h1;
   localparam logic [1:0] MODE_COND = 2'h2;

   // Register addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_INT_STAT = 8'h02;
   localparam logic [7:0] ADDR_INT_CLR = 8'h03;
   localparam logic [7:0] ADDR_INT_EN = 8'h04;
   localparam logic [7:0] ADDR_SLOT_BASE = 8'h20;
   localparam logic [7:0] ADDR_COND_BASE = 8'h40;
   localparam logic [7:0] ADDR_STEP_BASE = 8'h60;

   // Field positions
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_DSXEN_BIT = 1;
   localparam int CTRL_NETD4_BIT = 2;
   localparam int CTRL_DSXD4_BIT = 3;
   localparam int SLOT_KIND_LSB = 5;
   localparam int COND_USER_BIT = 2;
   localparam int COND_IDLE_LSB = 3;
   localparam int COND_HOLD_LSB = 7;
   localparam int EV_NET_CGA = 0;
   localparam int EV_DSX_CGA = 1;
   localparam int EV_REJECT = 2;

   // Reset values
   localparam logic [3:0] CTRL_RESET = 4'h1;
   localparam logic [10:0] COND_RESET = 11'h001;

   // Signaling codes
   localparam logic [3:0] ALL_ONES_SIG = 4'hf;
   localparam logic [3:0] D4_MASK = 4'hc;

   // Timing
   localparam int CLK_FREQ_HZ = 50_000_000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
   localparam int TICK_CNT_W = 16;
   localparam int IDLE_TIME_MS = 2000;
   localparam int IDLE_TICKS = IDLE_TIME_MS * 1000 / TICK_TIME_US;
   localparam int IDLE_CNT_W = 12;
   localparam logic [11:0] IDLE_LOAD = 12'(IDLE_TICKS + 1);
endpackage

//--- bench/t1_framer_model.sv
`timescale 1ns/10ps
// Framer stand-in: alarm levels and received signaling
module t1_framer_model (
   // Clock
   input wire logic clk_in,
   // Toward the block
   output logic valid_out,
   output logic [4:0] slot_out,
   output logic [3:0] sig_out,
   output logic los_out,
   output logic oof_out,
   output logic ais_out
);
   initial
   begin
      valid_out = 1'b0;
      slot_out = 5'h00;
      sig_out = 4'h0;
      {los_out, oof_out, ais_out} = 3'h0;
   end

   // One DS0 for one cycle, then inverted leftovers on the bus
   task automatic send(input logic [4:0] s, input logic [3:0] g);
      @(posedge clk_in);
      valid_out <= 1'b1;
      slot_out <= s;
      sig_out <= g;
      @(posedge clk_in);
      valid_out <= 1'b0;
      slot_out <= ~s;
      sig_out <= ~g;
   endtask

   // Alarm levels as loss, frame, ais
   task automatic alarm(input logic [2:0] a);
      @(posedge clk_in);
      {los_out, oof_out, ais_out} <= a;
   endtask
endmodule // t1_framer_model

//--- bench/t1_ds0_cross_connect_trunk_cond_tb.sv
`timescale 1ns/10ps
module t1_ds0_cross_connect_trunk_cond_tb;
   localparam int TK = 4;
   localparam logic [7:0] SB = xconn_pkg::ADDR_SLOT_BASE;
   localparam logic [7:0] CB = xconn_pkg::ADDR_COND_BASE;
   localparam logic [7:0] TB = xconn_pkg::ADDR_STEP_BASE;
   localparam logic [7:0] CT = xconn_pkg::ADDR_CTRL;
   localparam logic [7:0] ST = xconn_pkg::ADDR_STATUS;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_seen = 1'b0;
   logic [23:0] fr_det = 24'h000000;
   logic [15:0] rdata;
   logic irq, n_vld, n_los, n_oof, n_ais, d_vld, d_los, d_oof, d_ais;
   logic dt_vld, nt_vld;
   logic [4:0] n_slot, d_slot, dt_slot, nt_slot;
   logic [3:0] n_sig, d_sig, dt_sig, nt_sig;
   logic [15:0] exp_q [3][$];
   string nm [3] = '{"read data", "dsx tx", "net tx"};
   int failures = 0;
   int samples_checked = 0;
   int seed = 86919;

   slot_xconnect_core #(
      .NUM_SLOTS(xconn_pkg::NUM_SLOTS),
      .TICK_CYCLES(TK)
   ) i_dut (
      .SYS_CLK_IN(clk), .SYS_RST_IN(rst),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdata), .IRQ_OUT(irq),
      .NET_LOS_IN(n_los), .NET_OOF_IN(n_oof), .NET_AIS_IN(n_ais),
      .DSX_LOS_IN(d_los), .DSX_OOF_IN(d_oof), .DSX_AIS_IN(d_ais),
      .NET_FR_DETECT_IN(fr_det),
      .NET_RX_VALID_IN(n_vld), .NET_RX_SLOT_IN(n_slot),
      .NET_RX_SIG_IN(n_sig),
      .DSX_RX_VALID_IN(d_vld), .DSX_RX_SLOT_IN(d_slot),
      .DSX_RX_SIG_IN(d_sig),
      .DSX_TX_VALID_OUT(dt_vld), .DSX_TX_SLOT_OUT(dt_slot),
      .DSX_TX_SIG_OUT(dt_sig),
      .NET_TX_VALID_OUT(nt_vld), .NET_TX_SLOT_OUT(nt_slot),
      .NET_TX_SIG_OUT(nt_sig)
   );

   t1_framer_model i_net (
      .clk_in(clk), .valid_out(n_vld), .slot_out(n_slot),
      .sig_out(n_sig), .los_out(n_los), .oof_out(n_oof), .ais_out(n_ais)
   );

   t1_framer_model i_dsx (
      .clk_in(clk), .valid_out(d_vld), .slot_out(d_slot),
      .sig_out(d_sig), .los_out(d_los), .oof_out(d_oof), .ais_out(d_ais)
   );

   initial
   begin
      forever #10 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic ck(input string n, input logic [15:0] e,
      input logic [15:0] g);
      samples_checked++;
      if (e !== g)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask

   task automatic take(input int k, input logic [15:0] g);
      if (exp_q[k].size() == 0)
      begin
         $display("wrong value %s expected none seen %h", nm[k], g);
         failures++;
      end
      else
         ck(nm[k], exp_q[k].pop_front(), g);
   endtask

   // Result watcher
   always @(posedge clk)
   begin
      if (rd_seen)
         take(0, rdata);
      if (dt_vld === 1'b1)
         take(1, {7'h00, dt_slot, dt_sig});
      if (nt_vld === 1'b1)
         take(2, {7'h00, nt_slot, nt_sig});
      rd_seen <= rd;
   end

   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, input logic [15:0] e);
      exp_q[0].push_back(e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
   endtask

   function automatic logic [15:0] ex(input logic [4:0] s,
      input logic [3:0] g);
      return {7'h00, s, g};
   endfunction

   // Expectation 16'hffff means no output at all
   task automatic xn(input logic [4:0] s, input logic [3:0] g,
      input logic [15:0] e);
      if (e !== 16'hffff)
         exp_q[1].push_back(e);
      i_net.send(s, g);
   endtask

   task automatic xd(input logic [4:0] s, input logic [3:0] g,
      input logic [15:0] e);
      if (e !== 16'hffff)
         exp_q[2].push_back(e);
      i_dsx.send(s, g);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      failures++;
      give_verdict();
   end

   initial
   begin
      logic [3:0] g;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rreg(CT, 16'h0001);
      rreg(SB, 16'h0000);
      rreg(CB, 16'h0001);
      rreg(ST, 16'h0000);
      wreg(8'h10, 16'hffff);
      rreg(8'h10, 16'h0000);
      fr_det <= 24'h000020;
      w(3);
      rreg(SB + 8'h05, 16'h0020);
      rreg(SB + 8'h06, 16'h0000);
      wreg(SB + 8'h09, 16'h0043);
      rreg(SB + 8'h09, 16'h0000);
      rreg(xconn_pkg::ADDR_INT_STAT, 16'h0004);
      wreg(xconn_pkg::ADDR_INT_EN, 16'h0004);
      w(2);
      ck("irq", 16'h0001, {15'h0000, irq});
      wreg(xconn_pkg::ADDR_INT_CLR, 16'h0004);
      w(2);
      ck("irq", 16'h0000, {15'h0000, irq});
      wreg(CT, 16'h0002);
      w(2);
      fr_det <= 24'hffffff;
      w(3);
      rreg(SB + 8'h06, 16'h0000);
      rreg(SB + 8'h05, 16'h0020);
      wreg(SB + 8'h07, 16'h0020);
      rreg(SB + 8'h07, 16'h0020);
      wreg(SB + 8'h08, 16'h0043);
      wreg(SB + 8'h08, 16'h0020);
      rreg(SB + 8'h08, 16'h0043);
      wreg(SB + 8'h07, 16'h0044);
      rreg(SB + 8'h07, 16'h0020);
      wreg(SB + 8'h0a, 16'h0043);
      rreg(SB + 8'h0a, 16'h0000);
      wreg(SB + 8'h08, 16'h0043);
      rreg(SB + 8'h08, 16'h0043);
      wreg(TB + 8'h0b, 16'h0000);
      rreg(SB + 8'h0b, 16'h0040);
      wreg(TB + 8'h0b, 16'h0000);
      rreg(SB + 8'h0b, 16'h0041);
      for (int i = 0; i < 3; i++)
      begin
         wreg(TB + 8'h0c, 16'h0000);
         rreg(SB + 8'h0c, 16'h0040 | 16'(2 * i));
      end
      wreg(SB + 8'h0d, 16'h0057);
      wreg(TB + 8'h0d, 16'h0000);
      rreg(SB + 8'h0d, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         g = 4'($random(seed));
         xn(5'h08, g, ex(5'h03, g));
         xd(5'h03, g, ex(5'h08, g));
      end
      xn(5'h00, 4'h5, 16'hffff);
      xn(5'h07, 4'h5, 16'hffff);
      xd(5'h05, 4'h5, 16'hffff);
      xn(5'h0b, 4'h6, ex(5'h01, 4'h6));
      for (int k = 0; k < 3; k++)
      begin
         i_net.alarm(3'h4 >> k);
         w(3);
         xn(5'h08, 4'h5, ex(5'h03, 4'hf));
         xd(5'h03, 4'h5, ex(5'h08, 4'h5));
         i_net.alarm(3'h0);
         w(3);
      end
      xn(5'h08, 4'h5, ex(5'h03, 4'h5));
      wreg(CB + 8'h03, 16'h04b2);
      rreg(CB + 8'h03, 16'h04b2);
      i_net.alarm(3'h2);
      w(3);
      rreg(ST, 16'h0005);
      xn(5'h08, 4'ha, ex(5'h03, 4'h6));
      w((xconn_pkg::IDLE_TICKS - 5) * TK);
      xn(5'h08, 4'ha, ex(5'h03, 4'h6));
      w(6 * TK);
      xn(5'h08, 4'ha, ex(5'h03, 4'h9));
      wreg(CT, 16'h000a);
      xn(5'h08, 4'ha, ex(5'h03, 4'h8));
      i_net.alarm(3'h0);
      w(3);
      xn(5'h08, 4'ha, ex(5'h03, 4'ha));
      wreg(CB + 8'h03, 16'h0186);
      i_dsx.alarm(3'h1);
      w(3);
      xd(5'h03, 4'ha, ex(5'h08, 4'h3));
      xn(5'h08, 4'h5, ex(5'h03, 4'h5));
      wreg(CB + 8'h03, 16'h0000);
      xd(5'h03, 4'ha, ex(5'h08, 4'ha));
      i_dsx.alarm(3'h0);
      w(6);
      for (int k = 0; k < 3; k++)
         if (exp_q[k].size() != 0)
         begin
            $display("wrong value %s expected none seen %0d left", nm[k],
               exp_q[k].size());
            failures++;
         end
      give_verdict();
   end
endmodule // t1_ds0_cross_connect_trunk_cond_tb
